// File: shared/svrpc_pkg.sv
// constants, register map and state encoding of the supervisor reset / power-fail block
// assumes a 50 MHz reference clock and a byte-wide register port on word-aligned byte addresses
package svrpc_pkg;
   // time base
   localparam longint unsigned CLK_HZ          = 64'd50_000_000;   // reference clock rate
   localparam int              T_R1_MIN_NS     = 200;              // least low time, reset input one
   localparam int              T_R1_IGN_NS     = 50;               // narrower pulses never reset
   localparam int              T_R2_MIN_MS     = 100;              // least low time, reset input two
   localparam int              T_R2_IGN_MS     = 20;               // narrower pulses never reset
   localparam int              T_REC_LONG_MS   = 96;               // select 0, halt 0 (96..98 ms)
   localparam int              T_REC_DEF_MS    = 40;               // select 0, halt 1 (40..200 ms)
   localparam int              T_REC_SHORT_US  = 50;               // select 1 (50..2000 us)
   localparam int              T_BAT_CHECK_H   = 24;               // periodic battery check interval
   // cycle counts derived from the times, least times rounded up
   localparam int              R1_CYC    = int'((64'(T_R1_MIN_NS) * CLK_HZ + 64'd999_999_999) / 64'd1_000_000_000);
   localparam int              RECOVERY_INTERVAL_S_CYC = int'((64'(T_REC_SHORT_US) * CLK_HZ + 64'd999_999) / 64'd1_000_000);
   // counter widths
   localparam int              CW        = 24;                     // filter and recovery counters
   localparam int              DW        = 48;                     // daily battery check counter
   // register indices; byte address is four times the index
   localparam logic [4:0]      IDX_HALT  = 5'h01;                  // oscillator halt bit D7
   localparam logic [4:0]      IDX_CENT  = 5'h03;                  // century enable D7, flag D6
   localparam logic [4:0]      IDX_RECOVERY_INTERVAL  = 5'h04;                  // recovery length select D7
   localparam logic [4:0]      IDX_CTRL  = 5'h08;                  // general output D7, freq test D6
   localparam logic [4:0]      IDX_WDOG  = 5'h09;                  // watchdog register, 8 bits
   localparam logic [4:0]      IDX_ALRM  = 5'h0A;                  // alarm enable D7, sq wave D6, backup alarm D5
   localparam logic [4:0]      IDX_UPDH  = 5'h0C;                  // update halt D6
   localparam logic [4:0]      IDX_FLAG  = 5'h0F;                  // battery low D4, read only
   localparam logic [4:0]      IDX_ISTAT = 5'h10;                  // interrupt status, clear on read
   localparam logic [4:0]      IDX_IMASK = 5'h11;                  // interrupt mask
   // field positions
   localparam int              B_D7      = 7;
   localparam int              B_D6      = 6;
   localparam int              B_D5      = 5;
   localparam int              B_D4      = 4;
   // interrupt status bits
   localparam int              EV_RESET  = 0;                      // system reset asserted
   localparam int              EV_PFAIL  = 1;                      // early fail output fell
   localparam int              EV_BATLOW = 2;                      // battery check found low
   localparam int              EVW       = 3;
   // initial power-up values
   localparam logic            DEF_HALT  = 1'b1;
   localparam logic            DEF_OUT   = 1'b1;
   localparam logic            DEF_UPDH  = 1'b1;
   localparam logic [7:0]      WD_CLEAR  = 8'h00;
   // supervisor states
   typedef enum logic [2:0] {
      ST_BACKUP  = 3'b000,   // supply below deselect threshold
      ST_PWR_REC = 3'b001,   // supply back, recovery interval running
      ST_RUN     = 3'b010,   // normal operation
      ST_EXT_HLD = 3'b011,   // a reset input is held low
      ST_EXT_REC = 3'b100    // reset input released, recovery interval running
   } svrpc_state_type;
endpackage

// File: design/svrpc_top.sv
// supervisor block: reset inputs, timed system reset, early fail output, control bits, battery flag
// assumes pins arrive asynchronously, the analog comparator and battery test give logic levels,
// and the register master follows the one-cycle strobe protocol with read data one cycle later
`timescale 1ns/10ps

// What this block does
// - either reset input gives power-cycle reset
// - input one: 200 ns resets, <50 ns ignored
// - input two: 100 ms resets, <20 ms ignored
// - reset held for recovery interval after release
// - early fail low while monitor below threshold
// - backup: comparator off, early fail low
// - power return: early fail high during recovery
// - century flag toggles at rollover when enabled
// - general output bit drives interrupt pin while its other users are idle
// - battery checked at power-up and daily
// - battery low flag held until check passes
// - battery checks only on main supply
// - recovery select bit at D7 of 04h
// - interval chosen from select and halt bits
// - writes refused during power-up recovery
// - initial power-up default bit values
// - later power-up defaults, some bits kept
// - reset low below threshold and recovery
module svrpc_top #(
   parameter int              R2_CYC    = int'(64'(svrpc_pkg::T_R2_MIN_MS) * svrpc_pkg::CLK_HZ / 64'd1000),
   parameter int              RECOVERY_INTERVAL_L_CYC = int'(64'(svrpc_pkg::T_REC_LONG_MS) * svrpc_pkg::CLK_HZ / 64'd1000),
   parameter int              RECOVERY_INTERVAL_D_CYC = int'(64'(svrpc_pkg::T_REC_DEF_MS) * svrpc_pkg::CLK_HZ / 64'd1000),
   parameter longint unsigned DAY_CYC   = 64'(svrpc_pkg::T_BAT_CHECK_H) * 64'd3600 * svrpc_pkg::CLK_HZ
) (
   input  wire logic       ref_clk_in,             // 50 MHz reference
   input  wire logic       sys_rst_in,             // initial power application, async high
   input  wire logic       reset_input_one_in,     // pin, active low
   input  wire logic       reset_input_two_in,     // pin, active low
   input  wire logic       supply_monitor_low_in,  // comparator: monitor input below threshold
   input  wire logic       supply_ok_in,           // supply above deselect threshold
   input  wire logic       battery_weak_in,        // battery measures below limit
   input  wire logic       century_rollover_in,    // one-cycle pulse from the clock counters
   input  wire logic [7:0] addr_in,                // byte address
   input  wire logic [7:0] wdata_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   output logic      [7:0] rdata_out,
   output logic            sys_reset_drv_out,      // open-drain data, always low
   output logic            sys_reset_oe_n_out,     // low while the reset pin is pulled low
   output logic            early_fail_n_out,       // early fail output, active low
   output logic            irq_pin_drv_out,        // open-drain data, always low
   output logic            irq_pin_oe_n_out,       // low while the interrupt pin is pulled low
   output logic            interrupt_out           // level, unmasked status pending
);

   // whole state of the block
   typedef struct packed {
      logic [2:0]                s1, s2, scmp, ssup, sbat; // three-stage synchronisers
      logic                      r1, r2, cmp, sup, bat;     // agreed input levels
      logic [svrpc_pkg::CW-1:0]  c1, c2;                    // low-width counters
      logic                      r1_low, r2_low;            // confirmed reset requests
      svrpc_pkg::svrpc_state_type st;                       // supervisor state
      logic [svrpc_pkg::CW-1:0]  recovery_interval_cnt;                  // recovery interval counter
      logic [svrpc_pkg::DW-1:0]  day_cnt;                   // daily battery check counter
      logic                      cen_en, cen_flag, tr, halt, outb, ft;
      logic                      afe, square_wave_enable, abe, updh, bl;
      logic [7:0]                wd;                        // watchdog register
      logic [svrpc_pkg::EVW-1:0] ist, imask;                // interrupt status and mask
      logic [7:0]                rdata;
      logic                      rst_oe_n, pfo_n, irq_oe_n, irq;
   } svrpc_q_type;

   // constant reset image: pins idle high, supply absent, initial defaults
   localparam svrpc_q_type Q_RST = '{s1: '1, s2: '1, r1: 1'b1, r2: 1'b1, st: svrpc_pkg::ST_BACKUP,
                                     halt: svrpc_pkg::DEF_HALT, outb: svrpc_pkg::DEF_OUT,
                                     updh: svrpc_pkg::DEF_UPDH, irq_oe_n: svrpc_pkg::DEF_OUT,
                                     default: '0};

   svrpc_q_type q;     // registered state
   svrpc_q_type n;     // next state

   // next agreed level: changes once the second and third stages agree
   // a single-cycle glitch never fills two stages at once, so it is dropped
   function automatic logic agree(input logic [2:0] v, input logic old);
      agree = (v[1] == v[2]) ? v[2] : old;
   endfunction

   // recovery interval length from select and halt bits
   // the select bit wins: halt only matters while select is clear
   function automatic logic [svrpc_pkg::CW-1:0] recovery_interval_len(input logic sel, input logic hlt);
      if (sel) begin
         recovery_interval_len = svrpc_pkg::CW'(svrpc_pkg::RECOVERY_INTERVAL_S_CYC);
      end else if (hlt) begin
         recovery_interval_len = svrpc_pkg::CW'(RECOVERY_INTERVAL_D_CYC);
      end else begin
         recovery_interval_len = svrpc_pkg::CW'(RECOVERY_INTERVAL_L_CYC);
      end
   endfunction

   logic [4:0]                idx;       // register index of the access
   logic                      in_map;    // address word aligned and below 80h
   logic                      wr_ok;     // write accepted
   logic [svrpc_pkg::EVW-1:0] ev;        // events this cycle
   logic                      drv_mode;  // interrupt pin acts as plain output

   assign idx    = addr_in[6:2];
   assign in_map = (addr_in[1:0] == 2'b00) && !addr_in[7];

   // next-state logic
   always_comb begin
      n        = q;
      ev       = '0;
      drv_mode = 1'b0;
      // synchronisers: first stage feeds only the second
      n.s1   = {q.s1[1:0], reset_input_one_in};
      n.s2   = {q.s2[1:0], reset_input_two_in};
      n.scmp = {q.scmp[1:0], supply_monitor_low_in};
      n.ssup = {q.ssup[1:0], supply_ok_in};
      n.sbat = {q.sbat[1:0], battery_weak_in};
      n.r1   = agree(q.s1, q.r1);
      n.r2   = agree(q.s2, q.r2);
      n.cmp  = agree(q.scmp, q.cmp);
      n.sup  = agree(q.ssup, q.sup);
      n.bat  = agree(q.sbat, q.bat);

      // width filters: any high level restarts the count, so short pulses never reach the target
      if (q.r1) begin
         n.c1     = '0;
         n.r1_low = 1'b0;
      end else if (q.c1 < svrpc_pkg::CW'(svrpc_pkg::R1_CYC - 1)) begin
         n.c1 = q.c1 + 1'b1;
      end else begin
         n.r1_low = 1'b1;
      end
      if (q.r2) begin
         n.c2     = '0;
         n.r2_low = 1'b0;
      end else if (q.c2 < svrpc_pkg::CW'(R2_CYC - 1)) begin
         n.c2 = q.c2 + 1'b1;
      end else begin
         n.r2_low = 1'b1;
      end

      // register writes; refused while deselected or recovering from power loss
      wr_ok = wr_in && in_map && (q.st != svrpc_pkg::ST_PWR_REC) && (q.st != svrpc_pkg::ST_BACKUP);
      if (wr_ok) begin
         case (idx)
            svrpc_pkg::IDX_HALT: begin
               n.halt = wdata_in[svrpc_pkg::B_D7];
            end
            svrpc_pkg::IDX_CENT: begin
               n.cen_en   = wdata_in[svrpc_pkg::B_D7];
               n.cen_flag = wdata_in[svrpc_pkg::B_D6];
            end
            svrpc_pkg::IDX_RECOVERY_INTERVAL: begin
               n.tr = wdata_in[svrpc_pkg::B_D7];
            end
            svrpc_pkg::IDX_CTRL: begin
               n.outb = wdata_in[svrpc_pkg::B_D7];
               n.ft   = wdata_in[svrpc_pkg::B_D6];
            end
            svrpc_pkg::IDX_WDOG: begin
               n.wd = wdata_in;
            end
            svrpc_pkg::IDX_ALRM: begin
               n.afe  = wdata_in[svrpc_pkg::B_D7];
               n.square_wave_enable = wdata_in[svrpc_pkg::B_D6];
               n.abe  = wdata_in[svrpc_pkg::B_D5];
            end
            svrpc_pkg::IDX_UPDH: begin
               n.updh = wdata_in[svrpc_pkg::B_D6];
            end
            svrpc_pkg::IDX_IMASK: begin
               n.imask = wdata_in[svrpc_pkg::EVW-1:0];
            end
            default: begin
               n.imask = q.imask;                                    // read-only or unmapped
            end
         endcase
      end

      // century flag toggles after any write, so a rollover in a write cycle is kept
      if (century_rollover_in && n.cen_en) begin
         n.cen_flag = !n.cen_flag;
      end

      // supervisor sequence
      case (q.st)
         svrpc_pkg::ST_BACKUP: begin
            // deselected until the supply is agreed present
            if (q.sup) begin
               n.st       = svrpc_pkg::ST_PWR_REC;
               n.recovery_interval_cnt = '0;
               // later power-up: update halt set, selected bits cleared, others kept
               n.updh     = 1'b1;
               n.ft       = 1'b0;
               n.afe      = 1'b0;
               n.abe      = 1'b0;
               n.square_wave_enable     = 1'b0;
               n.wd       = svrpc_pkg::WD_CLEAR;
               // power-up battery check
               n.bl       = q.bat;
               ev[svrpc_pkg::EV_BATLOW] = q.bat;
               n.day_cnt  = '0;
            end
         end
         svrpc_pkg::ST_PWR_REC: begin
            // writes refused, early fail forced high
            if (q.recovery_interval_cnt >= recovery_interval_len(q.tr, q.halt) - 1'b1) begin
               n.st = svrpc_pkg::ST_RUN;
            end else begin
               n.recovery_interval_cnt = q.recovery_interval_cnt + 1'b1;
            end
         end
         svrpc_pkg::ST_RUN: begin
            // either confirmed request starts a hold
            if (q.r1_low || q.r2_low) begin
               n.st = svrpc_pkg::ST_EXT_HLD;
               ev[svrpc_pkg::EV_RESET] = 1'b1;
            end
         end
         svrpc_pkg::ST_EXT_HLD: begin
            // held while any input is still confirmed low
            if (!q.r1_low && !q.r2_low) begin
               n.st       = svrpc_pkg::ST_EXT_REC;
               n.recovery_interval_cnt = '0;
            end
         end
         svrpc_pkg::ST_EXT_REC: begin
            // a new request restarts the hold, the count is lost
            if (q.r1_low || q.r2_low) begin
               n.st = svrpc_pkg::ST_EXT_HLD;
            end else if (q.recovery_interval_cnt >= recovery_interval_len(q.tr, q.halt) - 1'b1) begin
               n.st = svrpc_pkg::ST_RUN;
            end else begin
               n.recovery_interval_cnt = q.recovery_interval_cnt + 1'b1;
            end
         end
         default: begin
            n.st = svrpc_pkg::ST_BACKUP;
         end
      endcase

      // loss of supply overrides everything
      if (!q.sup) begin
         n.st = svrpc_pkg::ST_BACKUP;
         ev[svrpc_pkg::EV_RESET] = (q.st != svrpc_pkg::ST_BACKUP);
      end

      // daily battery check runs only while the main supply is nominal
      if (q.sup && q.st != svrpc_pkg::ST_BACKUP && q.st != svrpc_pkg::ST_PWR_REC) begin
         if (q.day_cnt >= svrpc_pkg::DW'(DAY_CYC - 64'd1)) begin
            n.day_cnt = '0;
            n.bl      = q.bat;
            ev[svrpc_pkg::EV_BATLOW] = q.bat;
         end else begin
            n.day_cnt = q.day_cnt + 1'b1;
         end
      end

      // output images follow the next state so pins and state change together
      n.rst_oe_n = (n.st == svrpc_pkg::ST_RUN);
      case (n.st)
         svrpc_pkg::ST_BACKUP:  n.pfo_n = 1'b0;
         svrpc_pkg::ST_PWR_REC: n.pfo_n = 1'b1;
         default:               n.pfo_n = !n.cmp;
      endcase
      ev[svrpc_pkg::EV_PFAIL] = q.pfo_n && !n.pfo_n;

      // interrupt pin is a plain output only while its other users are idle
      drv_mode   = !n.ft && !n.afe && (n.wd == svrpc_pkg::WD_CLEAR);
      n.irq_oe_n = drv_mode ? n.outb : 1'b1;

      // read data, one cycle after the strobe; the status read clears it, new events win
      n.rdata = '0;
      if (rd_in && in_map) begin
         case (idx)
            svrpc_pkg::IDX_HALT:  n.rdata[svrpc_pkg::B_D7] = q.halt;
            svrpc_pkg::IDX_CENT:  n.rdata = {q.cen_en, q.cen_flag, 6'h00};
            svrpc_pkg::IDX_RECOVERY_INTERVAL:  n.rdata[svrpc_pkg::B_D7] = q.tr;
            svrpc_pkg::IDX_CTRL:  n.rdata = {q.outb, q.ft, 6'h00};
            svrpc_pkg::IDX_WDOG:  n.rdata = q.wd;
            svrpc_pkg::IDX_ALRM:  n.rdata = {q.afe, q.square_wave_enable, q.abe, 5'h00};
            svrpc_pkg::IDX_UPDH:  n.rdata[svrpc_pkg::B_D6] = q.updh;
            svrpc_pkg::IDX_FLAG:  n.rdata[svrpc_pkg::B_D4] = q.bl;
            svrpc_pkg::IDX_ISTAT: n.rdata[svrpc_pkg::EVW-1:0] = q.ist;
            svrpc_pkg::IDX_IMASK: n.rdata[svrpc_pkg::EVW-1:0] = q.imask;
            default:              n.rdata = '0;
         endcase
      end
      // status bits stay until read, so one-cycle events are never lost
      if (rd_in && in_map && idx == svrpc_pkg::IDX_ISTAT) begin
         n.ist = ev;
      end else begin
         n.ist = q.ist | ev;
      end
      n.irq = |(n.ist & n.imask);
   end

   // one register for the whole state; async reset is the initial power application
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         q <= Q_RST;
      end else begin
         q <= n;
      end
   end

   // pin data lines stay low: only the enables move, the pull-ups do the rest
   assign rdata_out          = q.rdata;
   assign sys_reset_drv_out  = 1'b0;
   assign sys_reset_oe_n_out = q.rst_oe_n;
   assign early_fail_n_out   = q.pfo_n;
   assign irq_pin_drv_out    = 1'b0;
   assign irq_pin_oe_n_out   = q.irq_oe_n;
   assign interrupt_out      = q.irq;

   // checks
   // recovery end: last recovery cycle, then normal run
   sequence s_rec_done;
      q.st == svrpc_pkg::ST_PWR_REC ##1 q.st == svrpc_pkg::ST_RUN;
   endsequence
   // input one agreed low five cycles, well short of its filter
   sequence s_short_low;
      !q.r1 [*5] ##1 q.r1;
   endsequence

   // pin levels in backup, across power-up recovery and in normal run
   AST_BACKUP_PFO: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      q.st == svrpc_pkg::ST_BACKUP |-> !early_fail_n_out && !sys_reset_oe_n_out)
      else $error("early fail or reset released in backup");

   AST_REC_PFO_HIGH: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      s_rec_done |-> $past(early_fail_n_out) && early_fail_n_out == !q.cmp)
      else $error("early fail not forced high then released");

   AST_PFO_FOLLOWS: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      q.st == svrpc_pkg::ST_RUN && $past(q.st) == svrpc_pkg::ST_RUN && $past(q.scmp[2:1]) == 2'b11
      |-> !early_fail_n_out)
      else $error("early fail not low with monitor low");

   // writes and reset timing
   AST_NO_WRITE_REC: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      q.st == svrpc_pkg::ST_PWR_REC && wr_in |=> $stable(q.wd) && $stable(q.tr) && $stable(q.outb))
      else $error("write taken during recovery");

   AST_EXT_REC_LOW: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      $rose(q.st == svrpc_pkg::ST_EXT_REC) |-> !sys_reset_oe_n_out [*8])
      else $error("reset released early after input release");

   AST_SHORT_PULSE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      q.r1 ##1 s_short_low |-> !q.r1_low)
      else $error("short low on input one gave a reset");

   // control bits and the interrupt pin
   AST_CENTURY: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      century_rollover_in && q.cen_en && !wr_in |=> q.cen_flag != $past(q.cen_flag))
      else $error("century flag did not toggle");

   AST_OUT_DRIVE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      !q.ft && !q.afe && q.wd == svrpc_pkg::WD_CLEAR |-> irq_pin_oe_n_out == q.outb)
      else $error("interrupt pin does not follow general output bit");

   // battery check, supply loss and power-up defaults
   AST_BAT_IDLE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      q.st == svrpc_pkg::ST_BACKUP ##1 q.st == svrpc_pkg::ST_BACKUP |-> $stable(q.bl) && $stable(q.day_cnt))
      else $error("battery check during backup");

   AST_SUPPLY_LOSS: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      !q.sup |=> q.st == svrpc_pkg::ST_BACKUP ##1 !sys_reset_oe_n_out)
      else $error("reset not pulled on supply loss");

   AST_POWERUP_DEF: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      q.st == svrpc_pkg::ST_BACKUP && q.sup |=> q.updh && !q.ft && !q.afe && q.wd == svrpc_pkg::WD_CLEAR)
      else $error("power-up defaults not applied");
endmodule

// File: tb/svrpc_host_model.sv
// host side: pulled-up open-drain wires, supply rails and two reset buttons
// assumes the bench calls its tasks just after a rising edge
`timescale 1ns/10ps
module svrpc_host_model (
   input  wire logic ref_clk_in,      // shared reference
   input  wire logic rst_oe_n_in,     // reset pin pull-down enable
   input  wire logic rst_drv_in,      // reset pin data
   input  wire logic irq_oe_n_in,     // interrupt pin pull-down enable
   input  wire logic irq_drv_in,      // interrupt pin data
   output logic      reset_pin_out,   // resolved reset wire
   output logic      irq_pin_out,     // resolved interrupt wire
   output logic      supply_ok_out,   // supply above deselect threshold
   output logic      monitor_low_out, // monitor below comparator threshold
   output logic      battery_weak_out,
   output logic      reset_input_one_out,
   output logic      reset_input_two_out
);
   // pull-ups win whenever nobody pulls low
   assign reset_pin_out = rst_oe_n_in ? 1'b1 : rst_drv_in;
   assign irq_pin_out   = irq_oe_n_in ? 1'b1 : irq_drv_in;
   // power off, buttons released at time zero
   initial begin
      supply_ok_out = 1'b0;
      monitor_low_out = 1'b0;
      battery_weak_out = 1'b0;
      reset_input_one_out = 1'b1;
      reset_input_two_out = 1'b1;
   end
   // move the rails at a clock edge
   task automatic rails(input logic ok, input logic mon, input logic bat);
      @(posedge ref_clk_in);
      supply_ok_out <= ok;
      monitor_low_out <= mon;
      battery_weak_out <= bat;
   endtask
   // hold one button low for n cycles, then the pull-up returns it
   task automatic press(input bit two, input int n);
      @(posedge ref_clk_in);
      if (two) reset_input_two_out <= 1'b0;
      else reset_input_one_out <= 1'b0;
      repeat (n) @(posedge ref_clk_in);
      reset_input_one_out <= 1'b1;
      reset_input_two_out <= 1'b1;
   endtask
endmodule

// File: tb/tb_supervisor_reset_powerfail_ctrl.sv
// bench: power cycles, reset buttons, intervals, register bits, interrupt
// assumes shortened counts: input two 40, recovery 30/20 cycles, day 100
`timescale 1ns/10ps
module tb_supervisor_reset_powerfail_ctrl;
   logic       ref_clk_in, sys_rst_in, wr, rd, roll, rst_oe_n, rst_drv, irq_oe_n, irq_drv, efail_n, intr;
   logic       rst_pin, irq_pin, sup_ok, mon_low, bat_weak, pin1, pin2;
   logic [7:0] addr, wdata, rdata;
   int         mismatches, n_compared;
   svrpc_top #(.R2_CYC(40), .RECOVERY_INTERVAL_L_CYC(30), .RECOVERY_INTERVAL_D_CYC(20), .DAY_CYC(64'd100)) dut (.ref_clk_in(ref_clk_in),
      .sys_rst_in(sys_rst_in), .reset_input_one_in(pin1), .reset_input_two_in(pin2), .supply_monitor_low_in(mon_low),
      .supply_ok_in(sup_ok), .battery_weak_in(bat_weak), .century_rollover_in(roll), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .sys_reset_drv_out(rst_drv), .sys_reset_oe_n_out(rst_oe_n),
      .early_fail_n_out(efail_n), .irq_pin_drv_out(irq_drv), .irq_pin_oe_n_out(irq_oe_n), .interrupt_out(intr));
   svrpc_host_model host (.ref_clk_in(ref_clk_in), .rst_oe_n_in(rst_oe_n), .rst_drv_in(rst_drv),
      .irq_oe_n_in(irq_oe_n), .irq_drv_in(irq_drv), .reset_pin_out(rst_pin), .irq_pin_out(irq_pin),
      .supply_ok_out(sup_ok), .monitor_low_out(mon_low), .battery_weak_out(bat_weak),
      .reset_input_one_out(pin1), .reset_input_two_out(pin2));
   initial begin
      ref_clk_in = 1'b0;
      forever #10 ref_clk_in = ~ref_clk_in;
   end
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_in);
      #1;
   endtask
   // one-cycle strobes; data read in the single cycle after the strobe
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge ref_clk_in);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      @(posedge ref_clk_in);
      addr <= a; rd <= 1'b1;
      @(posedge ref_clk_in);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   // count cycles until the reset wire shows lvl, bounded
   task automatic wait_rst(input logic lvl, output int n);
      for (n = 0; rst_pin !== lvl && n < 3000; n++) cyc(1);
      chk("rst_wait", n < 3000, 1);
   endtask
   task automatic t_power_up();
      logic [7:0] v;
      int n;
      host.rails(1'b1, 1'b1, 1'b0);
      cyc(8);
      chk("fail_forced", efail_n, 1);
      wr_reg(8'h10, 8'h80);
      wait_rst(1'b1, n);
      chk("pwr_rec", n + 10 >= 20 && n + 10 <= 30, 1);
      cyc(4);
      chk("fail_follows", efail_n, 0);
      rd_reg(8'h10, v); chk("wr_refused", v, 0);
      rd_reg(8'h04, v); chk("halt_def", v[7], 1);
      rd_reg(8'h20, v); chk("out_def", v[7], 1);
      rd_reg(8'h30, v); chk("updh_def", v[6], 1);
      rd_reg(8'h81, v); chk("unmapped", v, 0);
      host.rails(1'b1, 1'b0, 1'b0);
   endtask
   // short pulses ignored, long ones reset; then each interval setting
   task automatic t_pins();
      int n;
      int len [3] = '{20, 2500, 30};
      logic [7:0] sel [3] = '{8'h00, 8'h80, 8'h00};
      logic [7:0] hlt [3] = '{8'h80, 8'h80, 8'h00};
      for (int i = 0; i < 2; i++) begin
         host.press(i[0], i ? 30 : 5); cyc(8);
         chk("short_pulse", rst_pin, 1);
         host.press(i[0], i ? 50 : 20); cyc(2);
         chk("long_pulse", rst_pin, 0);
         wait_rst(1'b1, n);
      end
      for (int i = 0; i < 3; i++) begin
         wr_reg(8'h10, sel[i]); wr_reg(8'h04, hlt[i]);
         host.press(1'b0, 20); cyc(2);
         wait_rst(1'b1, n);
         chk("rec_len", n >= len[i] && n <= len[i] + 10, 1);
      end
   endtask
   task automatic t_fail_irq();
      logic [7:0] v;
      int n;
      rd_reg(8'h40, v);
      wr_reg(8'h44, 8'h02);
      cyc(1);
      chk("irq_quiet", intr, 0);
      host.rails(1'b1, 1'b1, 1'b0);
      cyc(8);
      chk("fail_low", efail_n, 0);
      chk("irq_set", intr, 1);
      rd_reg(8'h40, v); chk("ist_fail", v[1], 1); cyc(2);
      chk("irq_clr", intr, 0);
      wr_reg(8'h30, 8'h00); host.rails(1'b0, 1'b0, 1'b0); cyc(8);
      chk("bk_fail", efail_n, 0);
      chk("bk_rst", rst_pin, 0);
      host.rails(1'b1, 1'b0, 1'b0); wait_rst(1'b1, n);
      rd_reg(8'h30, v); chk("updh_set", v[6], 1);
      rd_reg(8'h04, v); chk("halt_kept", v[7], 0);
   endtask
   task automatic t_bits();
      logic [7:0] v;
      wr_reg(8'h20, 8'h00); cyc(2); chk("out_low", irq_pin, 0);
      wr_reg(8'h24, 8'h05);
      cyc(2);
      chk("wd_release", irq_pin, 1);
      wr_reg(8'h24, 8'h00);
      wr_reg(8'h20, 8'h80); cyc(2); chk("out_high", irq_pin, 1);
      for (int i = 0; i < 2; i++) begin
         wr_reg(8'h0C, i ? 8'h00 : 8'h80);
         @(posedge ref_clk_in) roll <= 1'b1;
         @(posedge ref_clk_in) roll <= 1'b0;
         rd_reg(8'h0C, v); chk("century", v[6], i ? 0 : 1);
      end
      host.rails(1'b1, 1'b0, 1'b1); cyc(150);
      rd_reg(8'h3C, v); chk("bat_low", v[4], 1);
      rd_reg(8'h40, v);
      chk("ist_bat", v[2], 1);
      host.rails(1'b1, 1'b0, 1'b0); cyc(150);
      rd_reg(8'h3C, v); chk("bat_ok", v[4], 0);
   endtask
   initial begin
      mismatches = 0; n_compared = 0; sys_rst_in = 1'b1;
      wr = 1'b0; rd = 1'b0; roll = 1'b0; addr = 8'h00; wdata = 8'h00;
      repeat (3) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      t_power_up(); t_pins(); t_fail_irq(); t_bits();
      conclude();
   end
   // hang guard, well past the expected run
   initial begin
      #1_000_000;
      mismatches++;
      conclude();
   end
endmodule
